/* File: dv/pcg_periph_model.sv */
// far-side model: source tick streams out, generated clocks in, edge and high counters out
`timescale 1ns/1ps
module pcg_periph_model
  import pcg_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [`PCG_NCH-1:0] gen_clk,
  output pcg_src_type src,
  output int edges [`PCG_NCH],
  output int highs [`PCG_NCH]
);
  // tick period of each source in hclk cycles, osc first
  localparam int PER [12] = '{2, 3, 4, 5, 3, 4, 1, 3, 4, 5, 6, 7};
  int cyc;
  logic [11:0] t;
  logic [`PCG_NCH-1:0] prev;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cyc <= 0;
      src <= '0;
      prev <= '0;
      foreach (edges[i]) edges[i] <= 0;
      foreach (highs[i]) highs[i] <= 0;
    end else begin
      for (int i = 0; i < 12; i++) t[11-i] = (cyc % PER[i]) == 0;
      cyc <= cyc + 1;
      src <= pcg_src_type'(t);
      prev <= gen_clk;
      for (int i = 0; i < `PCG_NCH; i++) begin
        if (gen_clk[i] && !prev[i]) edges[i] <= edges[i] + 1;
        if (gen_clk[i]) highs[i] <= highs[i] + 1;
      end
    end
  end
endmodule : pcg_periph_model

/* File: dv/peripheral_clock_generator_test.sv */
// self-checking bench of the peripheral clock generator
`timescale 1ns/1ps
module peripheral_clock_generator_test;
  import pcg_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  pcg_ahb_req_type req = '{hsize: 3'b010, default: '0};
  pcg_ahb_rsp_type rsp;
  pcg_src_type src;
  logic [`PCG_NCH-1:0] gen_clk;
  int edges [`PCG_NCH];
  int highs [`PCG_NCH];
  int errors = 0;
  int check_count = 0;
  logic [31:0] lfsr = 32'h44;
  logic [31:0] mdl [`PCG_NREG];
  localparam logic [7:0] OFF [`PCG_NREG] = '{8'h18, 8'h20, 8'h24, 8'h28, 8'h34, 8'h40,
    8'h44, 8'h48, 8'h4C, 8'h50, 8'h54, 8'h58, 8'h5C, 8'h60, 8'h64, 8'h68, 8'h6C, 8'h70,
    8'h7C, 8'h80};
  localparam logic [31:0] MSK [`PCG_NREG] = '{32'h4F, 32'h30F, 32'h730F, 32'h30F, 32'h31F,
    32'h3, 32'h3, 32'h3, 32'h3, 32'h3FF, 32'h3FF, 32'h3FF, 32'h3FF, 32'h3FF, 32'h3FF,
    32'h3FF, 32'h3FF, 32'h3FF, 32'h3, 32'hBB7D_5FD7};
  localparam int G0 [8] = '{1, 2, 3, 4, 6, 8, 12, 5};
  localparam int OV [4] = '{1, 2, 4, 3};
  always #20 hclk = ~hclk;
  pcg_ahb_req_type req_in;
  always_comb begin
    req_in = req;
    req_in.hready = rsp.hreadyout;
  end
  pcg_clock_gen u_pcg_clock_gen (.hclk(hclk), .hresetn(hresetn), .ahb_req(req_in),
    .ahb_rsp(rsp), .src(src), .gen_clk(gen_clk));
  pcg_periph_model u_pcg_periph_model (.hclk(hclk), .hresetn(hresetn),
    .gen_clk(gen_clk), .src(src), .edges(edges), .highs(highs));
  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : step
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] rd);
    req.hsel <= 1'b1;
    req.haddr <= a;
    req.hwrite <= w;
    req.htrans <= 2'b10;
    do begin
      @(posedge hclk);
    end while (rsp.hreadyout !== 1'b1);
    req.htrans <= 2'b00;
    req.hwdata <= d;
    do begin
      @(posedge hclk);
    end while (rsp.hreadyout !== 1'b1);
    rd = rsp.hrdata;
    chk("hresp", 32'h0, {31'h0, rsp.hresp});
  endtask : bus
  task automatic regs_zero();
    logic [31:0] rd;
    for (int i = 0; i < `PCG_NREG; i++) begin
      bus(1'b0, {24'h0, OFF[i]}, 32'h0, rd);
      chk("reset value", 32'h0, rd);
    end
  endtask : regs_zero
  task automatic run(input logic [7:0] a, input logic [31:0] v, input int ch, input int p,
      input int num, input int den, input bit inv);
    logic [31:0] rd;
    int w;
    int e;
    int h;
    bus(1'b1, {24'h0, a}, v, rd);
    w = (num == 0) ? 64 : p * num * 4;
    repeat (w / 2 + 8) @(posedge hclk);
    e = edges[ch];
    h = highs[ch];
    repeat (w) @(posedge hclk);
    e = edges[ch] - e;
    h = highs[ch] - h;
    if (num > 0 && e >= 4 * den - 1 && e <= 4 * den + 1) e = 4 * den;
    chk($sformatf("pulses ch%0d cfg %h", ch, v), 4 * den, e);
    chk($sformatf("level ch%0d cfg %h", ch, v), {31'h0, inv}, {31'h0, h * 2 > w});
  endtask : run
  initial begin
    repeat (90000) @(posedge hclk);
    errors++;
    finish_test();
  end
  initial begin
    logic [31:0] rd;
    int n;
    repeat (5) @(posedge hclk);
    chk("gen_clk in reset", '0, gen_clk);
    hresetn <= 1'b1;
    regs_zero();
    for (int i = 0; i < `PCG_NREG; i++) begin
      lfsr = step(lfsr);
      mdl[i] = lfsr & MSK[i];
      bus(1'b1, {24'h0, OFF[i]}, lfsr, rd);
    end
    bus(1'b1, 32'h84, 32'hFFFF_FFFF, rd);
    for (int i = 0; i < `PCG_NREG; i++) begin
      bus(1'b0, {24'h0, OFF[i]}, 32'h0, rd);
      chk("readback", mdl[i], rd);
    end
    bus(1'b0, 32'h1C, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    bus(1'b0, 32'h0100_0020, 32'h0, rd);
    chk("unmapped high", 32'h0, rd);
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    regs_zero();
    $display("test registers done");
    run(8'h18, 32'h0F, 0, 1, 16, 1, 0);
    run(8'h18, 32'h41, 0, 1, 256, 1, 0);
    for (int c = 0; c < 16; c++) begin
      n = (c == 0) ? 1 : (c == 14) ? 3 : (c == 15) ? 5 : 2 * c;
      run(8'h20, 32'h100 | c, 1, 2, n, (c >= 14) ? 2 : 1, 0);
    end
    for (int s = 0; s < 4; s++) begin
      run(8'h20, (s << 8) | 1, 1, s + 1, 2, 1, 0);
      run(8'h24, (s << 8) | 1, 2, s + 1, 2, 1, 0);
      run(8'h28, (s << 8) | 1, 3, s + 1, 2, 1, 0);
    end
    for (int c = 0; c < 8; c++) begin
      run(8'h24, (c << 12) | 32'h100, 4, 2, (c == 0) ? 1 : 2 * c, 1, 0);
    end
    for (int c = 0; c < 16; c++) begin
      run(8'h34, c, 5, 2, (c <= 11) ? c + 1 : 0, (c <= 11) ? 1 : 0, 0);
    end
    for (int s = 0; s < 4; s++) begin
      run(8'h34, (s << 8) | 32'h10, 5, s + 2, (s == 3) ? 0 : 6, (s == 3) ? 0 : 1, 0);
    end
    $display("test serial and display done");
    for (int r = 0; r < 4; r++) begin
      for (int c = 0; c < 4; c++) begin
        n = (c == 0) ? 1 : (c == 1) ? 24 : (c == 2 && r >= 2) ? 1 : 0;
        run(8'(8'h40 + 4 * r), c, 6 + r, (c == 2) ? r + 1 : 2, n, (n != 0), 0);
      end
    end
    for (int k = 0; k < 9; k++) begin
      run(8'(8'h50 + 4 * k), 32'h200 | k, 10 + k, 2, k + 1, 1, 0);
    end
    run(8'h50, 32'h003, 10, 5, 4, 1, 0);
    run(8'h70, 32'h2FF, 18, 2, 256, 1, 0);
    run(8'h70, 32'h300, 18, 2, 512, 1, 0);
    run(8'h70, 32'h301, 18, 2, 1024, 1, 0);
    run(8'h70, 32'h305, 18, 2, 0, 0, 0);
    for (int c = 0; c < 4; c++) begin
      n = (c == 0) ? 94 : (c == 1) ? 46 : (c == 2) ? 22 : 1;
      run(8'h7C, c, 19, (c == 3) ? 5 : 2, n, 1, 0);
    end
    $display("test counters and pulse width done");
    for (int c = 0; c < 16; c++) begin
      run(8'h80, ((c >> 3) << 4) | (c & 7), 20, 3, G0[c & 7] * ((c >> 3) + 1), 1, 0);
    end
    for (int s = 0; s < 4; s++) begin
      run(8'h80, (s << 6) | 1, 20, (s == 2) ? 2 : s + 3, (s == 3) ? 0 : 2, (s != 3), 0);
      run(8'h80, (s << 8) | 32'h400, 21, (s == 0) ? 3 : s + 4, (s == 3) ? 0 : 2, (s != 3),
        0);
      run(8'h80, s << 10, 21, 3, OV[s], 1, 0);
    end
    run(8'h80, 32'h0008_0400, 21, 3, 2, 1, 1);
    for (int g = 0; g < 2; g++) begin
      run(8'h80, 2 << (28 - 4 * g), 22 + g, 3, 0, 0, 0);
      run(8'h80, 3 << (28 - 4 * g), 22 + g, 3, 2, 1, 0);
      run(8'h80, 1 << (28 - 4 * g), 22 + g, 3, 1, 1, 0);
      run(8'h80, 9 << (28 - 4 * g), 22 + g, 3, 1, 1, 1);
    end
    for (int k = 0; k < 3; k++) begin
      run(8'h80, 0, 24 + k, 3, 0, 0, 0);
      run(8'h80, 1 << (20 - 4 * k), 24 + k, 3, 1, 1, 0);
      run(8'h80, 5 << (20 - 4 * k), 24 + k, 7, 1, 1, 0);
    end
    run(8'h80, 32'h0030_0000, 24, 3, 2, 1, 0);
    $display("test audio done");
    run(8'h20, 32'h003, 1, 1, 6, 1, 0);
    bus(1'b1, 32'h20, 32'h003, rd);
    repeat (2) @(posedge hclk);
    n = edges[1];
    repeat (4) @(posedge hclk);
    chk("restart gap", 32'h0, edges[1] - n);
    $display("test restart done");
    finish_test();
  end
endmodule : peripheral_clock_generator_test

/* File: hw/pcg_clock_gen.sv */
// peripheral clock generator: registers, source selects, dividers
`timescale 1ns/1ps
`include "pcg_consts.svh"
module pcg_clock_gen
  import pcg_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire pcg_ahb_req_type ahb_req,
  output pcg_ahb_rsp_type ahb_rsp,
  input wire pcg_src_type src,
  output logic [`PCG_NCH-1:0] gen_clk
);
  pcg_state_type st_reg;
  pcg_state_type st_next;
  logic [`PCG_NREG-1:0][31:0] r;
  logic [`PCG_NCH-1:0] ch_src;
  logic [`PCG_NCH-1:0] ch_run;
  logic [`PCG_NCH-1:0] ch_inv;
  logic [`PCG_NCH-1:0] ch_clr;
  logic [`PCG_NCH-1:0][`PCG_ACC_W-1:0] ch_num;
  logic [`PCG_NCH-1:0][1:0] ch_den;
  logic [`PCG_NCH-1:0][`PCG_ACC_W-1:0] acc_next;
  logic [`PCG_NCH-1:0] tick_next;

  assign r = st_reg.regs;

  function automatic logic [13:0] spi_num(input logic [3:0] c);
    if (c == 4'h0) return 14'h1;
    if (c == 4'hE) return 14'h3;
    if (c == 4'hF) return 14'h5;
    return {9'h0, c, 1'b0};
  endfunction : spi_num

  function automatic logic spi_src(input logic [1:0] s, input pcg_src_type x);
    unique case (s)
      2'h0: return 1'b1;
      2'h1: return x.osc_24mhz_clock;
      2'h2: return x.core_pll_clock;
      2'h3: return x.device_pll_clock;
    endcase
  endfunction : spi_src

  function automatic logic [13:0] pwm_num(input logic [8:0] c);
    if (c < 9'(`PCG_PWM_LIN_CODES)) return {5'h0, c} + 14'h1;
    return 14'(32'h200 << c[2:0]);
  endfunction : pwm_num

  function automatic logic [3:0] g0_num(input logic [2:0] c);
    unique case (c)
      3'h0: return 4'h1;
      3'h1: return 4'h2;
      3'h2: return 4'h3;
      3'h3: return 4'h4;
      3'h4: return 4'h6;
      3'h5: return 4'h8;
      3'h6: return 4'hC;
      3'h7: return 4'h5;
    endcase
  endfunction : g0_num

  function automatic logic [31:0] reg_mask(input logic [4:0] k);
    if (k == 5'(`PCG_R_CARD1)) return `PCG_MSK_CARD1;
    if (k == 5'(`PCG_R_SPI1)) return `PCG_MSK_SPI1;
    if (k <= 5'(`PCG_R_SPI2)) return `PCG_MSK_SPI;
    if (k == 5'(`PCG_R_LCD)) return `PCG_MSK_LCD;
    if (k < 5'(`PCG_R_PWM0)) return `PCG_MSK_CNT;
    if (k < 5'(`PCG_R_LRADC)) return `PCG_MSK_PWM;
    if (k == 5'(`PCG_R_LRADC)) return `PCG_MSK_LRADC;
    return `PCG_MSK_ADC01;
  endfunction : reg_mask

  // per-channel source tick, ratio num/den, run, invert and restart
  always_comb begin
    logic [1:0] sel;
    logic [3:0] div;
    logic [2:0] oc;
    logic [8:0] pc;
    logic [31:0] a;
    logic [4:0] k;
    sel = 2'h0;
    div = 4'h0;
    oc = 3'h0;
    pc = 9'h0;
    a = r[`PCG_R_ADC01];
    k = st_reg.wr_idx;
    for (int i = 0; i < `PCG_NCH; i++) begin
      ch_src[i] = 1'b0;
      ch_run[i] = 1'b1;
      ch_inv[i] = 1'b0;
      ch_clr[i] = 1'b0;
      ch_num[i] = 14'h1;
      ch_den[i] = 2'h1;
    end
    ch_src[`PCG_CH_CARD1] = src.card1_source;
    div = r[`PCG_R_CARD1][`PCG_DIV_LSB +: 4];
    ch_num[`PCG_CH_CARD1] = 14'(({10'h0, div} + 14'h1) *
      (r[`PCG_R_CARD1][`PCG_POST_BIT] ? `PCG_POST_DIV : 1));
    for (int i = 0; i < 3; i++) begin
      sel = r[`PCG_R_SPI0 + i][`PCG_SRC_LSB +: 2];
      div = r[`PCG_R_SPI0 + i][`PCG_DIV_LSB +: 4];
      ch_src[`PCG_CH_SPI0 + i] = spi_src(sel, src);
      ch_num[`PCG_CH_SPI0 + i] = spi_num(div);
      ch_den[`PCG_CH_SPI0 + i] = (div >= 4'hE) ? 2'h2 : 2'h1;
    end
    oc = r[`PCG_R_SPI1][`PCG_OCT_LSB +: 3];
    ch_src[`PCG_CH_OCT] = ch_src[`PCG_CH_SPI0 + 1];
    ch_num[`PCG_CH_OCT] = (oc == 3'h0) ? 14'h1 : {10'h0, oc, 1'b0};
    sel = r[`PCG_R_LCD][`PCG_SRC_LSB +: 2];
    div = r[`PCG_R_LCD][`PCG_DIV_LSB +: 4];
    ch_src[`PCG_CH_LCD] = (sel == 2'h0) ? src.osc_24mhz_clock :
      (sel == 2'h1) ? src.core_pll_clock : src.device_pll_clock;
    ch_run[`PCG_CH_LCD] = (sel != 2'h3) && (div <= 4'(`PCG_LCD_MAX_CODE));
    ch_num[`PCG_CH_LCD] = 14'(({10'h0, div} + 14'h1) *
      (r[`PCG_R_LCD][`PCG_LCD_PRE_BIT] ? `PCG_LCD_PRE_DIV : 1));
    for (int j = 0; j < 4; j++) begin
      sel = r[`PCG_R_CNT0 + j][1:0];
      ch_src[`PCG_CH_CNT0 + j] = (sel != 2'h2) ? src.osc_24mhz_clock :
        (j == 2) ? src.counter2_external_clock_pin : src.counter3_external_clock_pin;
      ch_num[`PCG_CH_CNT0 + j] = (sel == 2'h1) ? 14'(`PCG_CNT_SLOW_DIV) : 14'h1;
      ch_run[`PCG_CH_CNT0 + j] = (sel < 2'h2) || (sel == 2'h2 && j >= 2);
    end
    for (int p = 0; p < 9; p++) begin
      pc = r[`PCG_R_PWM0 + p][`PCG_DIV_LSB +: 9];
      ch_src[`PCG_CH_PWM0 + p] = r[`PCG_R_PWM0 + p][`PCG_PWM_SRC_BIT] ?
        src.osc_24mhz_clock : src.rc_32khz_clock;
      ch_num[`PCG_CH_PWM0 + p] = pwm_num(pc);
      ch_run[`PCG_CH_PWM0 + p] = pc <= 9'(`PCG_PWM_MAX_CODE);
    end
    sel = r[`PCG_R_LRADC][1:0];
    ch_src[`PCG_CH_LRADC] = (sel == 2'h3) ? src.rc_32khz_clock : src.osc_24mhz_clock;
    ch_num[`PCG_CH_LRADC] = (sel == 2'h0) ? 14'(`PCG_LR_DIV0) :
      (sel == 2'h1) ? 14'(`PCG_LR_DIV1) : (sel == 2'h2) ? 14'(`PCG_LR_DIV2) : 14'h1;
    sel = a[`PCG_G0_SRC_LSB +: 2];
    ch_src[`PCG_CH_G0] = (sel == 2'h0) ? src.audio_pll_first :
      (sel == 2'h1) ? src.audio_pll_second : src.osc_24mhz_clock;
    ch_run[`PCG_CH_G0] = sel != 2'h3;
    ch_num[`PCG_CH_G0] = 14'({10'h0, g0_num(a[`PCG_G0_DIV_LSB +: 3])} *
      (a[`PCG_G0_PRE_BIT] ? `PCG_G0_PRE_DIV : 1));
    sel = a[`PCG_P0_SRC_LSB +: 2];
    ch_src[`PCG_CH_ANA] = (sel == 2'h0) ? st_reg.tick[`PCG_CH_G0] :
      (sel == 2'h1) ? src.audio_tx0_master_clock : src.external_density_mod_clock;
    ch_run[`PCG_CH_ANA] = sel != 2'h3;
    sel = a[`PCG_OVS_LSB +: 2];
    ch_num[`PCG_CH_ANA] = (sel == 2'h3) ? 14'h3 : 14'(1 << sel);
    ch_inv[`PCG_CH_ANA] = a[`PCG_ANA_INV];
    ch_src[`PCG_CH_FIR] = st_reg.tick[`PCG_CH_ANA];
    ch_num[`PCG_CH_FIR] = a[`PCG_FIR_HALF] ? 14'(`PCG_HALF_DIV) : 14'h1;
    ch_run[`PCG_CH_FIR] = a[`PCG_FIR_GATE];
    ch_inv[`PCG_CH_FIR] = a[`PCG_FIR_INV];
    ch_src[`PCG_CH_CIC] = st_reg.tick[`PCG_CH_ANA];
    ch_num[`PCG_CH_CIC] = a[`PCG_CIC_HALF] ? 14'(`PCG_HALF_DIV) : 14'h1;
    ch_run[`PCG_CH_CIC] = a[`PCG_CIC_GATE];
    ch_inv[`PCG_CH_CIC] = a[`PCG_CIC_INV];
    ch_src[`PCG_CH_DMIC] = a[`PCG_DMIC_SRC] ? src.pair1_analog_clock :
      st_reg.tick[`PCG_CH_ANA];
    ch_num[`PCG_CH_DMIC] = a[`PCG_DMIC_HALF] ? 14'(`PCG_HALF_DIV) : 14'h1;
    ch_run[`PCG_CH_DMIC] = a[`PCG_DMIC_GATE];
    ch_src[`PCG_CH_LP] = a[`PCG_LP_SRC] ? src.pair1_analog_clock :
      st_reg.tick[`PCG_CH_ANA];
    ch_run[`PCG_CH_LP] = a[`PCG_LP_GATE];
    ch_src[`PCG_CH_SH] = a[`PCG_SH_SRC] ? src.pair1_analog_clock :
      st_reg.tick[`PCG_CH_ANA];
    ch_run[`PCG_CH_SH] = a[`PCG_SH_GATE];
    // a write restarts every channel its register steers
    if (st_reg.wr_pend) begin
      if (k == 5'(`PCG_R_CARD1)) begin
        ch_clr[`PCG_CH_CARD1] = 1'b1;
      end else if (k <= 5'(`PCG_R_SPI2)) begin
        ch_clr[`PCG_CH_SPI0 + int'(k) - `PCG_R_SPI0] = 1'b1;
        ch_clr[`PCG_CH_OCT] = k == 5'(`PCG_R_SPI1);
      end else if (k == 5'(`PCG_R_LCD)) begin
        ch_clr[`PCG_CH_LCD] = 1'b1;
      end else if (k < 5'(`PCG_R_LRADC)) begin
        ch_clr[`PCG_CH_CNT0 + int'(k) - `PCG_R_CNT0] = 1'b1;
      end else if (k == 5'(`PCG_R_LRADC)) begin
        ch_clr[`PCG_CH_LRADC] = 1'b1;
      end else begin
        ch_clr[`PCG_NCH-1:`PCG_CH_G0] = '1;
      end
    end
  end

  // rational divider: add den per source tick, emit when num reached
  for (genvar i = 0; i < `PCG_NCH; i++) begin : g_ch
    logic [`PCG_ACC_W:0] sum;
    logic emit;
    assign sum = {1'b0, st_reg.acc[i]} + {13'h0, ch_den[i]};
    assign emit = ch_src[i] & ch_run[i] & (sum >= {1'b0, ch_num[i]});
    assign tick_next[i] = emit & !ch_clr[i];
    assign acc_next[i] = (!ch_run[i] || ch_clr[i]) ? '0 :
      !ch_src[i] ? st_reg.acc[i] :
      emit ? sum[`PCG_ACC_W-1:0] - ch_num[i] : sum[`PCG_ACC_W-1:0];
  end

  always_comb begin
    logic hit;
    logic take;
    logic [4:0] idx;
    take = ahb_req.hsel & ahb_req.hready & ahb_req.htrans[1];
    st_next = st_reg;
    hit = 1'b0;
    idx = 5'h0;
    if (st_reg.wr_pend) begin
      st_next.regs[st_reg.wr_idx] = ahb_req.hwdata & reg_mask(st_reg.wr_idx);
    end
    for (int k = 0; k < `PCG_NREG; k++) begin
      if (ahb_req.haddr == {24'h0, PCG_OFFS[k]}) begin
        hit = 1'b1;
        idx = 5'(k);
      end
    end
    st_next.wr_pend = take & hit & ahb_req.hwrite;
    st_next.wr_idx = idx;
    // read sees a write landing on the same edge
    st_next.rdata = (take & hit & !ahb_req.hwrite) ? st_next.regs[idx] : 32'h0;
    st_next.acc = acc_next;
    st_next.tick = tick_next;
    for (int i = 0; i < `PCG_NCH; i++) begin
      st_next.clk[i] = ch_run[i] & (tick_next[i] ^ ch_inv[i]);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign ahb_rsp.hrdata = st_reg.rdata;
  assign ahb_rsp.hreadyout = 1'b1;
  assign ahb_rsp.hresp = 1'b0;
  assign gen_clk = st_reg.clk;

  logic a_fir_gate;
  assign a_fir_gate = r[`PCG_R_ADC01][`PCG_FIR_GATE];

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_spi_frac_cfg;
    (r[`PCG_R_SPI0] == 32'h0000_000E && !st_reg.wr_pend)[*3];
  endsequence
  sequence s_two_ticks;
    st_reg.tick[`PCG_CH_SPI0] ##1 st_reg.tick[`PCG_CH_SPI0];
  endsequence

  chk_card1_source: assert property (
    st_reg.tick[`PCG_CH_CARD1] |-> $past(src.card1_source))
    else $error("card1 tick without source tick");
  chk_spi_default: assert property (
    (r[`PCG_R_SPI0] == 32'h0 && !st_reg.wr_pend)[*2] |=> st_reg.tick[`PCG_CH_SPI0])
    else $error("spi0 default not bus clock divided by one");
  chk_spi_fraction: assert property (
    s_spi_frac_cfg ##0 s_two_ticks |=> !st_reg.tick[`PCG_CH_SPI0])
    else $error("spi0 ratio 1.5 gave three ticks in a row");
  chk_lcd_src_rsv: assert property (
    r[`PCG_R_LCD][9:8] == 2'h3 |=> !gen_clk[`PCG_CH_LCD])
    else $error("lcd reserved source produced a clock");
  chk_lcd_div_rsv: assert property (
    r[`PCG_R_LCD][3:0] > 4'hB |=> !gen_clk[`PCG_CH_LCD])
    else $error("lcd reserved divisor produced a clock");
  chk_cnt0_rsv: assert property (
    r[`PCG_R_CNT0][1] |=> !gen_clk[`PCG_CH_CNT0])
    else $error("counter0 reserved source produced a clock");
  chk_cnt2_ext: assert property (
    (r[`PCG_R_CNT0 + 2][1:0] == 2'h2 && !st_reg.wr_pend
      && src.counter2_external_clock_pin) |=> gen_clk[`PCG_CH_CNT0 + 2])
    else $error("counter2 missed external pin tick");
  chk_pwm_rsv: assert property (
    r[`PCG_R_PWM0][8:0] > 9'h104 |=> !gen_clk[`PCG_CH_PWM0])
    else $error("pwm0 reserved divisor produced a clock");
  chk_lradc_rc: assert property (
    (r[`PCG_R_LRADC][1:0] == 2'h3 && !st_reg.wr_pend && src.rc_32khz_clock)
      |=> gen_clk[`PCG_CH_LRADC])
    else $error("low-rate adc missed 32k tick");
  chk_fir_gate: assert property (
    !a_fir_gate |=> !gen_clk[`PCG_CH_FIR])
    else $error("fir clock ran while gated");
  chk_ana_invert: assert property (
    (r[`PCG_R_ADC01][19] && r[`PCG_R_ADC01][9:8] != 2'h3)
      |=> gen_clk[`PCG_CH_ANA] == !st_reg.tick[`PCG_CH_ANA])
    else $error("pair0 analog clock not inverted");
  chk_write_restart: assert property (
    (st_reg.wr_pend && st_reg.wr_idx == 5'h4) |=> !st_reg.tick[`PCG_CH_LCD])
    else $error("lcd clock ticked right after reconfiguration");
  chk_card1_post: assert property (
    (st_reg.tick[`PCG_CH_CARD1] && r[`PCG_R_CARD1][`PCG_POST_BIT])
      |=> !st_reg.tick[`PCG_CH_CARD1])
    else $error("card1 post-divided clock ticked on two cycles in a row");
  chk_spi_osc: assert property (
    (r[`PCG_R_SPI0] == 32'h0000_0100 && !st_reg.wr_pend && src.osc_24mhz_clock)
      |=> st_reg.tick[`PCG_CH_SPI0])
    else $error("spi0 missed 24 MHz source tick");
  chk_oct_unit: assert property (
    (r[`PCG_R_SPI1] == 32'h0 && !st_reg.wr_pend) |=> st_reg.tick[`PCG_CH_OCT])
    else $error("octal double-rate clock not bus clock divided by one");
  chk_lcd_pre: assert property (
    (st_reg.tick[`PCG_CH_LCD] && r[`PCG_R_LCD][`PCG_LCD_PRE_BIT])
      |=> !st_reg.tick[`PCG_CH_LCD])
    else $error("display pre-divided clock ticked on two cycles in a row");
  chk_pwm_rc: assert property (
    (r[`PCG_R_PWM0] == 32'h0 && !st_reg.wr_pend && src.rc_32khz_clock)
      |=> st_reg.tick[`PCG_CH_PWM0])
    else $error("pwm0 missed 32 kHz source tick");
  chk_g0_pre: assert property (
    (st_reg.tick[`PCG_CH_G0] && r[`PCG_R_ADC01][`PCG_G0_PRE_BIT])
      |=> !st_reg.tick[`PCG_CH_G0])
    else $error("group0 pre-divided clock ticked on two cycles in a row");
  chk_dmic_gate: assert property (
    !r[`PCG_R_ADC01][`PCG_DMIC_GATE] |=> !gen_clk[`PCG_CH_DMIC])
    else $error("digital mic clock ran while gated");
  chk_lp_gate: assert property (
    !r[`PCG_R_ADC01][`PCG_LP_GATE] |=> !gen_clk[`PCG_CH_LP])
    else $error("low-power adc analog clock ran while gated");
  chk_sh_gate: assert property (
    !r[`PCG_R_ADC01][`PCG_SH_GATE] |=> !gen_clk[`PCG_CH_SH])
    else $error("shared adc analog clock ran while gated");
endmodule : pcg_clock_gen

/* File: hw/pcg_consts.svh */
// constants of the peripheral clock generator
`ifndef PCG_CONSTS_SVH
`define PCG_CONSTS_SVH
`define PCG_NREG 20
`define PCG_NCH 27
`define PCG_ACC_W 14
`define PCG_RST_VAL 32'h0000_0000
`define PCG_OFF_CARD1 8'h18
`define PCG_OFF_SPI0 8'h20
`define PCG_OFF_SPI1 8'h24
`define PCG_OFF_SPI2 8'h28
`define PCG_OFF_LCD 8'h34
`define PCG_OFF_CNT0 8'h40
`define PCG_OFF_CNT1 8'h44
`define PCG_OFF_CNT2 8'h48
`define PCG_OFF_CNT3 8'h4C
`define PCG_OFF_PWM0 8'h50
`define PCG_OFF_PWM1 8'h54
`define PCG_OFF_PWM2 8'h58
`define PCG_OFF_PWM3 8'h5C
`define PCG_OFF_PWM4 8'h60
`define PCG_OFF_PWM5 8'h64
`define PCG_OFF_PWM6 8'h68
`define PCG_OFF_PWM7 8'h6C
`define PCG_OFF_PWM8 8'h70
`define PCG_OFF_LRADC 8'h7C
`define PCG_OFF_ADC01 8'h80
`define PCG_MSK_CARD1 32'h0000_004F
`define PCG_MSK_SPI 32'h0000_030F
`define PCG_MSK_SPI1 32'h0000_730F
`define PCG_MSK_LCD 32'h0000_031F
`define PCG_MSK_CNT 32'h0000_0003
`define PCG_MSK_PWM 32'h0000_03FF
`define PCG_MSK_LRADC 32'h0000_0003
`define PCG_MSK_ADC01 32'hBB7D_5FD7
`define PCG_R_CARD1 0
`define PCG_R_SPI0 1
`define PCG_R_SPI1 2
`define PCG_R_SPI2 3
`define PCG_R_LCD 4
`define PCG_R_CNT0 5
`define PCG_R_PWM0 9
`define PCG_R_LRADC 18
`define PCG_R_ADC01 19
`define PCG_CH_CARD1 0
`define PCG_CH_SPI0 1
`define PCG_CH_OCT 4
`define PCG_CH_LCD 5
`define PCG_CH_CNT0 6
`define PCG_CH_PWM0 10
`define PCG_CH_LRADC 19
`define PCG_CH_G0 20
`define PCG_CH_ANA 21
`define PCG_CH_FIR 22
`define PCG_CH_CIC 23
`define PCG_CH_DMIC 24
`define PCG_CH_LP 25
`define PCG_CH_SH 26
`define PCG_SRC_LSB 8
`define PCG_DIV_LSB 0
`define PCG_POST_BIT 6
`define PCG_OCT_LSB 12
`define PCG_LCD_PRE_BIT 4
`define PCG_PWM_SRC_BIT 9
`define PCG_FIR_INV 31
`define PCG_FIR_HALF 29
`define PCG_FIR_GATE 28
`define PCG_CIC_INV 27
`define PCG_CIC_HALF 25
`define PCG_CIC_GATE 24
`define PCG_DMIC_SRC 22
`define PCG_DMIC_HALF 21
`define PCG_DMIC_GATE 20
`define PCG_ANA_INV 19
`define PCG_LP_SRC 18
`define PCG_LP_GATE 16
`define PCG_SH_SRC 14
`define PCG_SH_GATE 12
`define PCG_OVS_LSB 10
`define PCG_P0_SRC_LSB 8
`define PCG_G0_SRC_LSB 6
`define PCG_G0_PRE_BIT 4
`define PCG_G0_DIV_LSB 0
`define PCG_POST_DIV 128
`define PCG_LCD_PRE_DIV 6
`define PCG_G0_PRE_DIV 2
`define PCG_HALF_DIV 2
`define PCG_CNT_SLOW_DIV 24
`define PCG_LR_DIV0 94
`define PCG_LR_DIV1 46
`define PCG_LR_DIV2 22
`define PCG_LCD_MAX_CODE 11
`define PCG_PWM_LIN_CODES 256
`define PCG_PWM_MAX_CODE 260
`endif

/* File: hw/pcg_pkg.sv */
// types of the peripheral clock generator
package pcg_pkg;
  `include "pcg_consts.svh"
  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } pcg_ahb_req_type;
  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } pcg_ahb_rsp_type;
  // each field is a one-cycle tick per rising edge of that source
  typedef struct packed {
    logic osc_24mhz_clock;
    logic core_pll_clock;
    logic device_pll_clock;
    logic rc_32khz_clock;
    logic audio_pll_first;
    logic audio_pll_second;
    logic card1_source;
    logic counter2_external_clock_pin;
    logic counter3_external_clock_pin;
    logic audio_tx0_master_clock;
    logic external_density_mod_clock;
    logic pair1_analog_clock;
  } pcg_src_type;
  typedef struct packed {
    logic [`PCG_NREG-1:0][31:0] regs;
    logic [`PCG_NCH-1:0][`PCG_ACC_W-1:0] acc;
    logic [`PCG_NCH-1:0] tick;
    logic [`PCG_NCH-1:0] clk;
    logic wr_pend;
    logic [4:0] wr_idx;
    logic [31:0] rdata;
  } pcg_state_type;
  localparam logic [`PCG_NREG-1:0][7:0] PCG_OFFS = {
    `PCG_OFF_ADC01, `PCG_OFF_LRADC, `PCG_OFF_PWM8, `PCG_OFF_PWM7,
    `PCG_OFF_PWM6, `PCG_OFF_PWM5, `PCG_OFF_PWM4, `PCG_OFF_PWM3,
    `PCG_OFF_PWM2, `PCG_OFF_PWM1, `PCG_OFF_PWM0, `PCG_OFF_CNT3,
    `PCG_OFF_CNT2, `PCG_OFF_CNT1, `PCG_OFF_CNT0, `PCG_OFF_LCD,
    `PCG_OFF_SPI2, `PCG_OFF_SPI1, `PCG_OFF_SPI0, `PCG_OFF_CARD1};
endpackage : pcg_pkg
